// ===== rsq_pkg.sv
package rsq_pkg;

    // Command codes
    localparam logic [5:0] CMD_IDLE = 6'h00;
    localparam logic [5:0] CMD_TRANSMIT = 6'h1A;
    localparam logic [5:0] CMD_POWER_UP_INIT_COMMAND = 6'h3F;

    // APB byte offsets
    localparam logic [7:0] ADDR_PAGE = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COMMAND = 8'h08;
    localparam logic [7:0] ADDR_FIFO_DATA = 8'h0C;
    localparam logic [7:0] ADDR_FIFO_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_IRQ = 8'h14;
    localparam logic [7:0] ADDR_FRAME_CHECK = 8'h18;
    localparam logic [7:0] ADDR_PARTIAL_BYTE = 8'h1C;

    // Field positions
    localparam int FCC_PARITY_BIT = 0;
    localparam int FCC_ODD_BIT = 1;
    localparam int FCC_CRC_BIT = 2;
    localparam int IRQ_CMD_DONE_BIT = 0;
    localparam int IRQ_SEND_DONE_BIT = 1;
    localparam int STATUS_PHASE_LSB = 4;

    // Values loaded by the initialization phase (stand-ins for nonvolatile contents) and the number of load steps
    localparam logic [3:0] EE_FRAME_CHECK = 4'h3;
    localparam logic [6:0] EE_PAGE = 7'h00;
    localparam logic [2:0] INIT_LOAD_STEPS = 3'h2;

    // Frame check
    localparam logic [15:0] CRC_PRESET = 16'h6363;
    localparam logic [15:0] CRC_POLY = 16'h8408;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int BIT_TIME_NS = 9440;
    localparam int BIT_CYCLES = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Link phase codes
    localparam logic [2:0] PH_IDLE = 3'h0;
    localparam logic [2:0] PH_WAIT = 3'h1;
    localparam logic [2:0] PH_SOF = 3'h2;
    localparam logic [2:0] PH_DATA = 3'h3;
    localparam logic [2:0] PH_EOF = 3'h4;

    typedef enum logic [2:0] {
        ST_POWER_UP_INIT_COMMAND = 3'b000,
        ST_LOAD = 3'b001,
        ST_IDLE = 3'b011,
        ST_ARMED = 3'b010,
        ST_SOF = 3'b110,
        ST_DATA = 3'b111,
        ST_EOF = 3'b101
    } rsq_state_t;

endpackage

// ===== rsq_top.sv
// Contract
// RULE1 - Init runs only after power or pin reset
// RULE2 - Init: reset register bits, then load values; the FIFO level count is not cleared
// RULE3 - Init end executes idle command automatically
// RULE4 - Host polls for idle before any write
// RULE5 - During init only page register reads succeed
// RULE6 - Init cannot be interrupted by host
// RULE7 - Host idle aborts command without done flag
// RULE8 - Command finishing itself sets command done flag
// RULE9 - Abort leaves FIFO data and level intact
// RULE10 - Transmit starts only by host command write
// RULE11 - Host may preload up to 64 bytes
// RULE12 - Transmit on empty FIFO waits for data
// RULE13 - Bytes written during transmit are appended
// RULE14 - Empty FIFO at byte request ends transmit
// RULE15 - Finished frame sets send done flag
// RULE16 - Other command halts sending next clock
// RULE17 - Frame is SOF, data, EOF; phase reported
// RULE18 - Optional CRC append; parity per configuration
// RULE19 - Nonzero last bit count shortens final byte
// RULE20 - Parity after full bytes only
// RULE21 - Last bit count cleared after transmission
// RULE22 - Host clears CRC enable for partial bytes
// RULE23 - Partial byte sent LSB first, then EOF
// RULE24 - FIFO checked one bit before last bit
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module rsq_top #(
    parameter int FIFO_DEPTH = 64,
    parameter int BIT_CYCLES = rsq_pkg::BIT_CYCLES
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic DIGITAL_SUPPLY_POR_I,
    input wire logic ANALOG_SUPPLY_POR_I,
    input wire logic RESET_POWERDOWN_PIN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic TX_O,
    output logic TX_EN_O
);

    localparam int AW = $clog2(FIFO_DEPTH);

    typedef struct packed {
        rsq_pkg::rsq_state_t st;
        logic [5:0] cmd;
        logic [6:0] page;
        logic [3:0] fcc;
        logic [2:0] last_bits;
        logic [1:0] irq;
        logic [FIFO_DEPTH-1:0][7:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [15:0] tmr;
        logic [3:0] pos;
        logic [3:0] nbits;
        logic par_on;
        logic par_bit;
        logic partial;
        logic [7:0] sh;
        logic [15:0] crc;
        logic [1:0] crc_idx;
        logic more;
        logic [2:0] init_cnt;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic tx;
        logic tx_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rsq_regs_t;

    rsq_regs_t r_reg;
    rsq_regs_t r_next;

    logic acc;
    logic done;
    logic busy;
    logic tx_state;
    logic trig;
    logic tick;
    logic wr;
    logic cmd_wr;
    logic halt;
    logic err;
    logic push;
    logic pop;
    logic ld;
    logic ld_fifo;
    logic [7:0] ld_byte;
    logic [7:0] rd;
    logic [3:0] unit_len;
    logic [2:0] phase;
    logic avail;
    logic cbit;

    assign acc = PSEL_I & PENABLE_I;
    assign done = acc & r_reg.pready;
    assign busy = (r_reg.st == rsq_pkg::ST_POWER_UP_INIT_COMMAND) || (r_reg.st == rsq_pkg::ST_LOAD);
    assign tx_state = (r_reg.st == rsq_pkg::ST_ARMED) || (r_reg.st == rsq_pkg::ST_SOF) ||
                      (r_reg.st == rsq_pkg::ST_DATA) || (r_reg.st == rsq_pkg::ST_EOF);
    // Rising supply POR or falling pin edge, synchronised
    assign trig = (r_reg.s2[0] & ~r_reg.s3[0]) | (r_reg.s2[1] & ~r_reg.s3[1]) |
                  (~r_reg.s2[2] & r_reg.s3[2]); // RULE1
    assign tick = (r_reg.tmr == 16'h0000);
    assign unit_len = r_reg.nbits + {3'b000, r_reg.par_on};
    assign cbit = r_reg.sh[r_reg.pos[2:0]];

    always_comb begin
        case (r_reg.st)
            rsq_pkg::ST_ARMED: phase = rsq_pkg::PH_WAIT;
            rsq_pkg::ST_SOF: phase = rsq_pkg::PH_SOF;
            rsq_pkg::ST_DATA: phase = rsq_pkg::PH_DATA;
            rsq_pkg::ST_EOF: phase = rsq_pkg::PH_EOF;
            default: phase = rsq_pkg::PH_IDLE;
        endcase
    end

    always_comb begin
        r_next = r_reg;
        push = 1'b0;
        pop = 1'b0;
        ld = 1'b0;
        ld_fifo = 1'b0;
        ld_byte = 8'h00;
        rd = 8'h00;
        err = 1'b0;
        avail = 1'b0;
        r_next.s1 = {RESET_POWERDOWN_PIN_I, ANALOG_SUPPLY_POR_I, DIGITAL_SUPPLY_POR_I};
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;

        // Register read decode
        case (PADDR_I)
            rsq_pkg::ADDR_PAGE: rd = {busy, r_reg.page};
            rsq_pkg::ADDR_STATUS: rd = {1'b0, phase, 1'b0, 1'b0,
                                        r_reg.cnt == (AW+1)'(FIFO_DEPTH), r_reg.cnt == '0};
            rsq_pkg::ADDR_COMMAND: rd = {2'b00, r_reg.cmd};
            rsq_pkg::ADDR_FIFO_DATA: rd = 8'h00;
            rsq_pkg::ADDR_FIFO_LEVEL: rd = 8'(r_reg.cnt);
            rsq_pkg::ADDR_IRQ: rd = {6'h00, r_reg.irq};
            rsq_pkg::ADDR_FRAME_CHECK: rd = {4'h0, r_reg.fcc};
            rsq_pkg::ADDR_PARTIAL_BYTE: rd = {5'h00, r_reg.last_bits};
            default: err = 1'b1;
        endcase
        if (busy && (PWRITE_I || PADDR_I != rsq_pkg::ADDR_PAGE)) begin
            err = 1'b1; // RULE5
        end
        if (PWRITE_I && PADDR_I == rsq_pkg::ADDR_COMMAND && PWDATA_I[5:0] == rsq_pkg::CMD_POWER_UP_INIT_COMMAND) begin
            err = 1'b1; // RULE1
        end
        r_next.pready = acc & ~r_reg.pready;
        r_next.pslverr = acc & ~r_reg.pready & err;
        r_next.prdata = (acc & ~r_reg.pready & ~PWRITE_I & ~err) ? {24'h00_0000, rd} : 32'h0000_0000;

        wr = done & PWRITE_I & ~r_reg.pslverr;
        cmd_wr = wr && (PADDR_I == rsq_pkg::ADDR_COMMAND);
        halt = cmd_wr && tx_state && (PWDATA_I[5:0] != rsq_pkg::CMD_TRANSMIT); // RULE16
        if (wr && PADDR_I == rsq_pkg::ADDR_IRQ) begin
            r_next.irq = r_reg.irq & ~PWDATA_I[1:0];
        end
        if (tx_state && r_reg.st != rsq_pkg::ST_ARMED) begin
            r_next.tmr = tick ? 16'(BIT_CYCLES - 1) : r_reg.tmr - 16'h0001;
        end

        if (!halt) begin
            case (r_reg.st)
                rsq_pkg::ST_POWER_UP_INIT_COMMAND: begin
                    // Reset phase
                    r_next.cmd = rsq_pkg::CMD_POWER_UP_INIT_COMMAND; // RULE2
                    r_next.fcc = 4'h0;
                    r_next.last_bits = 3'h0;
                    r_next.irq = 2'b00;
                    r_next.page = 7'h00;
                    r_next.wp = '0;
                    r_next.rp = '0;
                    r_next.cnt = '0;
                    r_next.init_cnt = 3'h0;
                    r_next.st = rsq_pkg::ST_LOAD;
                end
                rsq_pkg::ST_LOAD: begin
                    // Load phase, one register per step
                    case (r_reg.init_cnt)
                        3'h0: r_next.fcc = rsq_pkg::EE_FRAME_CHECK; // RULE2
                        default: r_next.page = rsq_pkg::EE_PAGE;
                    endcase
                    r_next.init_cnt = r_reg.init_cnt + 3'h1;
                    if (r_reg.init_cnt == rsq_pkg::INIT_LOAD_STEPS - 3'h1) begin
                        r_next.st = rsq_pkg::ST_IDLE; // RULE3 RULE6
                        r_next.cmd = rsq_pkg::CMD_IDLE;
                        r_next.irq[rsq_pkg::IRQ_CMD_DONE_BIT] = 1'b1; // RULE8
                    end
                end
                rsq_pkg::ST_ARMED: begin
                    if (r_reg.cnt != '0) begin
                        r_next.st = rsq_pkg::ST_SOF; // RULE12
                        r_next.tmr = 16'(BIT_CYCLES - 1);
                        r_next.crc = rsq_pkg::CRC_PRESET;
                        r_next.crc_idx = 2'b00;
                    end
                end
                rsq_pkg::ST_SOF: begin
                    if (tick) begin
                        ld = 1'b1;
                        ld_fifo = 1'b1;
                    end
                end
                rsq_pkg::ST_DATA: begin
                    if (tick) begin
                        if (r_reg.pos < r_reg.nbits && r_reg.crc_idx == 2'b00) begin
                            r_next.crc = (r_reg.crc >> 1) ^
                                         ((r_reg.crc[0] ^ cbit) ? rsq_pkg::CRC_POLY : 16'h0000); // RULE18
                        end
                        if (r_reg.pos == unit_len - 4'h1) begin
                            avail = (unit_len == 4'h1) ? (r_reg.cnt != '0) : r_reg.more;
                            if (!r_reg.partial && r_reg.crc_idx == 2'b00 && avail && r_reg.cnt != '0) begin
                                ld = 1'b1; // RULE13
                                ld_fifo = 1'b1;
                            end else if (!r_reg.partial && r_reg.fcc[rsq_pkg::FCC_CRC_BIT] &&
                                         r_reg.crc_idx != 2'b10) begin
                                ld = 1'b1; // RULE18
                                ld_byte = (r_reg.crc_idx == 2'b00) ? r_next.crc[7:0] : r_reg.crc[15:8];
                                r_next.crc_idx = r_reg.crc_idx + 2'b01;
                            end else begin
                                r_next.st = rsq_pkg::ST_EOF; // RULE14 RULE23
                            end
                        end else begin
                            r_next.pos = r_reg.pos + 4'h1;
                            if (r_reg.pos == unit_len - 4'h2) begin
                                r_next.more = (r_reg.cnt != '0); // RULE24
                            end
                        end
                    end
                end
                rsq_pkg::ST_EOF: begin
                    if (tick) begin
                        r_next.st = rsq_pkg::ST_IDLE; // RULE17
                        r_next.cmd = rsq_pkg::CMD_IDLE;
                        r_next.irq = 2'b11; // RULE8 RULE15
                        r_next.last_bits = 3'h0; // RULE21
                    end
                end
                default: begin
                end
            endcase
        end

        if (ld) begin
            if (ld_fifo) begin
                pop = 1'b1;
                ld_byte = r_reg.mem[r_reg.rp];
                r_next.partial = (r_reg.last_bits != 3'h0) && (r_reg.cnt == (AW+1)'(1)); // RULE19
            end else begin
                r_next.partial = 1'b0;
            end
            r_next.sh = ld_byte;
            r_next.nbits = r_next.partial ? {1'b0, r_reg.last_bits} : 4'h8; // RULE19
            r_next.par_on = r_reg.fcc[rsq_pkg::FCC_PARITY_BIT] & ~r_next.partial; // RULE20
            r_next.par_bit = ^ld_byte ^ r_reg.fcc[rsq_pkg::FCC_ODD_BIT]; // RULE18
            r_next.pos = 4'h0;
            r_next.more = 1'b0;
            r_next.st = rsq_pkg::ST_DATA;
        end

        if (wr) begin
            case (PADDR_I)
                rsq_pkg::ADDR_PAGE: r_next.page = PWDATA_I[6:0];
                rsq_pkg::ADDR_FRAME_CHECK: r_next.fcc = PWDATA_I[3:0];
                rsq_pkg::ADDR_PARTIAL_BYTE: r_next.last_bits = PWDATA_I[2:0];
                rsq_pkg::ADDR_FIFO_DATA: push = (r_reg.cnt != (AW+1)'(FIFO_DEPTH)) || pop;
                rsq_pkg::ADDR_COMMAND: begin
                    if (halt || !tx_state) begin
                        // Abort keeps FIFO untouched and raises no flag
                        r_next.st = rsq_pkg::ST_IDLE; // RULE7 RULE9
                        r_next.cmd = rsq_pkg::CMD_IDLE;
                        if (!tx_state && PWDATA_I[5:0] == rsq_pkg::CMD_TRANSMIT) begin
                            r_next.st = rsq_pkg::ST_ARMED; // RULE10
                            r_next.cmd = rsq_pkg::CMD_TRANSMIT;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (push) begin
            r_next.mem[r_reg.wp] = PWDATA_I[7:0];
            r_next.wp = r_reg.wp + AW'(1);
        end
        if (pop) begin
            r_next.rp = r_reg.rp + AW'(1);
        end
        r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);

        if (trig) begin
            r_next.st = rsq_pkg::ST_POWER_UP_INIT_COMMAND; // RULE1
        end
        case (r_next.st)
            rsq_pkg::ST_SOF: r_next.tx = 1'b1;
            rsq_pkg::ST_DATA: r_next.tx = (r_next.pos < r_next.nbits) ? r_next.sh[r_next.pos[2:0]]
                                                                      : r_next.par_bit;
            default: r_next.tx = 1'b0;
        endcase
        r_next.tx_en = (r_next.st == rsq_pkg::ST_SOF) || (r_next.st == rsq_pkg::ST_DATA) ||
                       (r_next.st == rsq_pkg::ST_EOF); // RULE17
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign PRDATA_O = r_reg.prdata;
    assign PREADY_O = r_reg.pready;
    assign PSLVERR_O = r_reg.pslverr;
    assign TX_O = r_reg.tx;
    assign TX_EN_O = r_reg.tx_en;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    sequence host_stop;
        done && PWRITE_I && PADDR_I == rsq_pkg::ADDR_COMMAND && !r_reg.pslverr && tx_state &&
        PWDATA_I[5:0] != rsq_pkg::CMD_TRANSMIT;
    endsequence

    sequence eof_end;
        r_reg.st == rsq_pkg::ST_EOF && tick && !(done && PWRITE_I) && !trig;
    endsequence

    chk_power_up_init_command_cause: assert property ( // RULE1
        (r_reg.st == rsq_pkg::ST_POWER_UP_INIT_COMMAND && $past(r_reg.st) != rsq_pkg::ST_POWER_UP_INIT_COMMAND) |-> $past(trig))
        else $error("init entered without reset event");
    chk_power_up_init_command_idle: assert property ( // RULE3
        $fell(busy) |-> r_reg.cmd == rsq_pkg::CMD_IDLE && r_reg.irq[rsq_pkg::IRQ_CMD_DONE_BIT])
        else $error("init did not end in idle with done flag");
    chk_busy_read_refused: assert property ( // RULE5
        (busy && acc && !r_reg.pready && PADDR_I != rsq_pkg::ADDR_PAGE && !trig) |=> r_reg.pslverr && PREADY_O)
        else $error("access during init not refused");
    chk_load_runs_through: assert property ( // RULE6
        (r_reg.st == rsq_pkg::ST_LOAD && !trig) |=> r_reg.st inside {rsq_pkg::ST_LOAD, rsq_pkg::ST_IDLE})
        else $error("init interrupted");
    chk_abort_quiet: assert property ( // RULE7 RULE9 RULE16
        (host_stop and (!trig && r_reg.st != rsq_pkg::ST_LOAD)) |=>
        !r_reg.tx_en && r_reg.cnt == $past(r_reg.cnt) && r_reg.irq == $past(r_reg.irq))
        else $error("abort changed FIFO, flags or kept sending");
    chk_empty_waits: assert property ( // RULE12
        (r_reg.st == rsq_pkg::ST_ARMED && r_reg.cnt == '0 && !trig) |=> !r_reg.tx_en)
        else $error("sending started with empty FIFO");
    chk_frame_done: assert property ( // RULE15 RULE21
        eof_end |=> r_reg.irq == 2'b11 && r_reg.last_bits == 3'h0 && r_reg.st == rsq_pkg::ST_IDLE)
        else $error("frame end flags or bit count wrong");
    chk_more_sample: assert property ( // RULE24
        (r_reg.st == rsq_pkg::ST_DATA && tick && unit_len > 4'h1 && r_reg.pos == unit_len - 4'h2 && !halt)
        |=> r_reg.more == $past(r_reg.cnt != '0))
        else $error("FIFO check point wrong");
    chk_partial_parity: assert property ( // RULE20
        (r_reg.st == rsq_pkg::ST_DATA && r_reg.partial) |-> !r_reg.par_on && r_reg.nbits == {1'b0, r_reg.last_bits})
        else $error("partial byte framing wrong");

endmodule

`default_nettype wire

// ===== rsq_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module rsq_host_model (
    input wire logic clk_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0000_0000;
    end

    // Request held until pready is seen high at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= wr;
        paddr_o <= addr;
        pwdata_o <= wdata;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        rdata = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ===== reader_power_up_init_command_idle_transmit_seq_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module reader_power_up_init_command_idle_transmit_seq_tb_top;
    localparam int BITC = 16;
    localparam logic [7:0] A_PAGE = rsq_pkg::ADDR_PAGE;
    localparam logic [7:0] A_STAT = rsq_pkg::ADDR_STATUS;
    localparam logic [7:0] A_CMD = rsq_pkg::ADDR_COMMAND;
    localparam logic [7:0] A_FIFO = rsq_pkg::ADDR_FIFO_DATA;
    localparam logic [7:0] A_LVL = rsq_pkg::ADDR_FIFO_LEVEL;
    localparam logic [7:0] A_IRQ = rsq_pkg::ADDR_IRQ;
    localparam logic [7:0] A_FCC = rsq_pkg::ADDR_FRAME_CHECK;
    localparam logic [7:0] A_PART = rsq_pkg::ADDR_PARTIAL_BYTE;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic por_d = 1'b0;
    logic por_a = 1'b0;
    logic pin_n = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, tx, tx_en, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] c;
    logic rx_q[$];
    logic exp_q[$];
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int tcnt = 0;

    always #10 clk = ~clk;

    rsq_top #(.FIFO_DEPTH(64), .BIT_CYCLES(BITC)) rsq_top_inst (
        .CLK_I(clk), .RST_I(rst), .DIGITAL_SUPPLY_POR_I(por_d), .ANALOG_SUPPLY_POR_I(por_a),
        .RESET_POWERDOWN_PIN_I(pin_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .TX_O(tx), .TX_EN_O(tx_en));

    rsq_host_model rsq_host_model_inst (
        .clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

    // Sample each bit in the middle of its bit time
    always @(posedge clk) begin
        if (tx_en === 1'b1) begin
            if (tcnt % BITC == BITC / 2) rx_q.push_back(tx);
            tcnt++;
        end else begin
            tcnt = 0;
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        rsq_host_model_inst.xfer(1'b1, a, d, rd, er);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rsq_host_model_inst.xfer(1'b0, a, 32'h0000_0000, rd, er);
        check($sformatf("reg %h", a), rd, exp);
    endtask

    // Wait for the power_up_init_command sequence to finish before any write
    task automatic poll;
        int k;
        k = 0;
        rd = 32'h0000_0080;
        while (rd[7] !== 1'b0 && k < 100) begin
            rsq_host_model_inst.xfer(1'b0, A_PAGE, 32'h0000_0000, rd, er);
            check("page read err", {31'h0, er}, 32'h0000_0000);
            k++;
        end
    endtask

    task automatic add_byte(input logic [7:0] b, input int n, input logic par, input logic odd);
        for (int i = 0; i < n; i++) exp_q.push_back(b[i]);
        if (par && n == 8) exp_q.push_back(odd ? ~^b : ^b);
    endtask

    function automatic logic [15:0] crc_step(input logic [15:0] cin, input logic [7:0] b);
        logic [15:0] r;
        r = cin;
        for (int i = 0; i < 8; i++) r = ((r[0] ^ b[i]) === 1'b1) ? ((r >> 1) ^ rsq_pkg::CRC_POLY) : (r >> 1);
        return r;
    endfunction

    task automatic frame_chk;
        int k;
        k = 0;
        exp_q.push_front(1'b1);
        exp_q.push_back(1'b0);
        while (tx_en !== 1'b1 && k < 100) begin
            @(posedge clk);
            k++;
        end
        while (tx_en === 1'b1 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        @(posedge clk);
        check("frame length", rx_q.size(), exp_q.size());
        for (int i = 0; i < exp_q.size() && i < rx_q.size(); i++) begin
            check($sformatf("frame bit %0d", i), {31'h0, rx_q[i]}, {31'h0, exp_q[i]});
        end
        rx_q.delete();
        exp_q.delete();
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        poll();
        rdc(A_CMD, 32'h0000_0000);
        rdc(A_IRQ, 32'h0000_0001);
        rdc(A_FCC, 32'h0000_0003);
        wr(A_CMD, 32'h0000_003F);
        check("power_up_init_command by write", {31'h0, er}, 32'h0000_0001);
        rdc(A_CMD, 32'h0000_0000);
        wr(8'h40, 32'h0000_0001);
        check("unmapped err", {31'h0, er}, 32'h0000_0001);
        for (int t = 0; t < 3; t++) begin
            wr(A_FCC, 32'h0000_0000);
            wr(A_IRQ, 32'h0000_0003);
            if (t == 0) por_d <= 1'b1;
            else if (t == 1) por_a <= 1'b1;
            else pin_n <= 1'b0;
            repeat (2) @(posedge clk);
            wr(A_CMD, 32'h0000_001A);
            check("write during init", {31'h0, er}, 32'h0000_0001);
            poll();
            por_d <= 1'b0;
            por_a <= 1'b0;
            pin_n <= 1'b1;
            rdc(A_FCC, 32'h0000_0003);
            rdc(A_CMD, 32'h0000_0000);
            rdc(A_IRQ, 32'h0000_0001);
        end
        // Preloaded frame, even parity
        wr(A_FCC, 32'h0000_0001);
        wr(A_FIFO, 32'h0000_00A5);
        wr(A_FIFO, 32'h0000_003C);
        add_byte(8'hA5, 8, 1'b1, 1'b0);
        add_byte(8'h3C, 8, 1'b1, 1'b0);
        wr(A_CMD, 32'h0000_001A);
        frame_chk();
        rdc(A_IRQ, 32'h0000_0003);
        rdc(A_CMD, 32'h0000_0000);
        rdc(A_STAT, 32'h0000_0001);
        // Odd parity with CRC appended
        wr(A_FCC, 32'h0000_0007);
        wr(A_FIFO, 32'h0000_0093);
        wr(A_FIFO, 32'h0000_0020);
        c = crc_step(crc_step(rsq_pkg::CRC_PRESET, 8'h93), 8'h20);
        add_byte(8'h93, 8, 1'b1, 1'b1);
        add_byte(8'h20, 8, 1'b1, 1'b1);
        add_byte(c[7:0], 8, 1'b1, 1'b1);
        add_byte(c[15:8], 8, 1'b1, 1'b1);
        wr(A_CMD, 32'h0000_001A);
        frame_chk();
        // Partial last byte, CRC off
        wr(A_FCC, 32'h0000_0001);
        wr(A_PART, 32'h0000_0003);
        wr(A_FIFO, 32'h0000_005A);
        wr(A_FIFO, 32'h0000_000D);
        add_byte(8'h5A, 8, 1'b1, 1'b0);
        add_byte(8'h0D, 3, 1'b1, 1'b0);
        wr(A_CMD, 32'h0000_001A);
        frame_chk();
        rdc(A_PART, 32'h0000_0000);
        // Armed on empty FIFO, data supplied afterwards
        wr(A_FCC, 32'h0000_0000);
        wr(A_IRQ, 32'h0000_0003);
        wr(A_CMD, 32'h0000_001A);
        rdc(A_STAT, 32'h0000_0011);
        check("idle line armed", {31'h0, tx_en}, 32'h0000_0000);
        wr(A_FIFO, 32'h0000_0081);
        wr(A_FIFO, 32'h0000_007E);
        add_byte(8'h81, 8, 1'b0, 1'b0);
        add_byte(8'h7E, 8, 1'b0, 1'b0);
        frame_chk();
        rdc(A_IRQ, 32'h0000_0003);
        // Abort while the start pattern is on the line
        wr(A_FCC, 32'h0000_0001);
        wr(A_IRQ, 32'h0000_0003);
        wr(A_FIFO, 32'h0000_0011);
        wr(A_FIFO, 32'h0000_0022);
        wr(A_FIFO, 32'h0000_0033);
        wr(A_CMD, 32'h0000_001A);
        rdc(A_STAT, 32'h0000_0020);
        rdc(A_LVL, 32'h0000_0003);
        wr(A_CMD, 32'h0000_0000);
        @(posedge clk);
        #1;
        check("line after abort", {31'h0, tx_en}, 32'h0000_0000);
        rdc(A_IRQ, 32'h0000_0000);
        rdc(A_LVL, 32'h0000_0003);
        rdc(A_CMD, 32'h0000_0000);
        // Bytes kept by the abort go out intact
        rx_q.delete();
        add_byte(8'h11, 8, 1'b1, 1'b0);
        add_byte(8'h22, 8, 1'b1, 1'b0);
        add_byte(8'h33, 8, 1'b1, 1'b0);
        wr(A_CMD, 32'h0000_001A);
        frame_chk();
        end_of_test();
    end
endmodule

`default_nettype wire
